// ### bpc_pkg.sv
/*
 * Shared constants and types for the boot-and-pattern command logic:
 * command codes, status and boot-configuration field positions, reset
 * values, timing counts and the controller's register map.
 * Assumes a 40 MHz system clock on both ends.
 */
package bpc_pkg;
   // timing
   localparam int         CLK_PERIOD_NS = 25;
   localparam int         CLK_FREQ_MHZ  = 40;
   localparam int         SCK_PERIOD_NS = 200;
   localparam logic [3:0] SCK_HALF_CYC  = 4'(SCK_PERIOD_NS / (2 * CLK_PERIOD_NS));
   localparam int         BUSY_TIME_US  = 10;
   localparam logic [11:0] BUSY_CYC     = 12'(BUSY_TIME_US * CLK_FREQ_MHZ);

   // command codes
   localparam logic [7:0] CMD_CLEAR_FAIL_FLAGS = 8'h30;
   localparam logic [7:0] CMD_BOOT_REG_READ    = 8'h14;
   localparam logic [7:0] CMD_BOOT_REG_WRITE   = 8'h15;
   localparam logic [7:0] CMD_PERSIST_PROGRAM  = 8'h43;
   localparam logic [7:0] CMD_VOLATILE_WRITE   = 8'h4A;
   localparam logic [7:0] CMD_PATTERN_READ     = 8'h41;
   localparam logic [7:0] CMD_WRITE_LATCH_SET  = 8'h06;
   localparam logic [7:0] CMD_STATUS_READ      = 8'h05;

   // status_reg_one and config_reg_one bits
   localparam int SR1_WIP_BIT   = 0;
   localparam int SR1_WEL_BIT   = 1;
   localparam int SR1_E_ERR_BIT = 5;
   localparam int SR1_P_ERR_BIT = 6;
   localparam int CR1_QUAD_BIT  = 1;

   // boot_start_config fields
   localparam int BOOT_EN_BIT   = 0;
   localparam int BOOT_DLY_LSB  = 1;
   localparam int BOOT_ADDR_LSB = 9;

   // values after reset
   localparam logic [31:0] BOOT_REG_RESET = 32'h0000_0000;
   localparam logic [7:0]  PATTERN_RESET  = 8'h00;

   // controller register map (byte offsets)
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_TXDATA = 8'h04;
   localparam logic [7:0] REG_RXDATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;

   // controller ctrl fields
   localparam int CTRL_CMD_LSB   = 0;
   localparam int CTRL_TXLEN_LSB = 8;
   localparam int CTRL_RXLEN_LSB = 14;
   localparam int CTRL_DUMMY_LSB = 20;
   localparam int CTRL_NOCMD_BIT = 28;
   localparam int CTRL_QUAD_BIT  = 29;

   typedef enum logic [2:0] {
      DEV_IDLE, DEV_CMD, DEV_HOLD, DEV_SKIP, DEV_WDATA, DEV_READ, DEV_BOOT_WAIT, DEV_BOOT_DATA
   } bpc_dev_state_t;

   typedef enum logic [2:0] {
      HST_IDLE, HST_CMD, HST_TX, HST_DUMMY, HST_RX, HST_END
   } bpc_host_state_t;
endpackage

// ### bpc_spi_if.sv
/*
 * Serial link between the controller and the device end.
 * Resolves the four data lines from both ends' enables; an undriven
 * line reads high, as with a pull-up.
 */
`timescale 1ns/100ps
interface bpc_spi_if;
   logic       sck;
   logic       cs_n;
   logic       host_si;
   logic       host_si_oe_n;
   logic [3:0] dev_io;
   logic [3:0] dev_io_oe_n;
   logic [3:0] io;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         io[i] = 1'b1;
         if (!dev_io_oe_n[i]) begin
            io[i] = dev_io[i];
         end else if (i == 0 && !host_si_oe_n) begin
            io[i] = host_si;
         end
      end
   end

   modport device (input sck, input cs_n, input io, output dev_io, output dev_io_oe_n);
   modport host (output sck, output cs_n, output host_si, output host_si_oe_n, input io);
endinterface

// ### bpc_device.sv
/*
 * Device end: command interpreter for fail-flag clear, boot streaming,
 * boot register read/write and learning-pattern commands.
 * Assumes the link pins are asynchronous to clk (sampled through two
 * flops) and an array that answers mem_data for mem_addr within a few clks.
 */
`timescale 1ns/100ps
module bpc_device #(
   parameter logic [31:0] BOOT_INIT    = bpc_pkg::BOOT_REG_RESET,
   parameter logic [7:0]  PATTERN_INIT = bpc_pkg::PATTERN_RESET
) (
   // system
   input  wire logic        clk,
   input  wire logic        nrst,
   // hardware or command reset event, one-cycle pulse
   input  wire logic        reset_evt,
   // configuration
   input  wire logic [7:0]  config_reg_one,
   // boot array
   output logic [31:0]      mem_addr,
   input  wire logic [7:0]  mem_data,
   // outcome of self-timed operations
   input  wire logic        erase_fail,
   input  wire logic        program_fail,
   // register view
   output logic [7:0]       status_reg_one,
   output logic [31:0]      boot_start_config,
   output logic [7:0]       learning_pattern,
   // link
   bpc_spi_if.device        spi
);
   function automatic logic [31:0] swap32(input logic [31:0] w);
      swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction

   bpc_pkg::bpc_dev_state_t state;
   bpc_pkg::bpc_dev_state_t next_cmd_state;
   logic [2:0]  sck_q;
   logic [2:0]  cs_q;
   logic [3:0]  io_q1;
   logic [3:0]  io_q2;
   logic [5:0]  bit_cnt;
   logic [31:0] rx;
   logic [7:0]  cmd_l;
   logic [31:0] tx;
   logic [31:0] read_word;
   logic        skip;
   logic [3:0]  nib;
   logic [7:0]  dly;
   logic        quad_b;
   logic        armed;
   logic        first_byte;
   logic [11:0] busy_cnt;
   logic        op_boot_reg_write_cmd;
   logic [31:0] pend;
   logic        write_enable_latch;
   logic        e_err;
   logic        p_err;
   logic [7:0]  pers_pat;
   logic        sck_rise;
   logic        sck_fall;
   logic        cs_rise;
   logic        cs_fall;
   logic        si;
   logic [7:0]  cmd_in;
   logic        write_in_progress;
   logic        op_done;
   logic        boot_load;
   logic [7:0]  boot_dly;
   logic [3:0]  nib_load;
   logic        ev_write_latch_set_cmd;
   logic        ev_clear_fail_flags_cmd;
   logic        ev_boot_reg_write_cmd;
   logic        ev_pnv;
   logic        ev_wv;

   // pin synchronisers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sck_q <= 3'h0;
         cs_q  <= 3'h7;
         io_q1 <= 4'hF;
         io_q2 <= 4'hF;
      end else begin
         sck_q <= {sck_q[1:0], spi.sck};
         cs_q  <= {cs_q[1:0], spi.cs_n};
         io_q1 <= spi.io;
         io_q2 <= io_q1;
      end
   end

   assign sck_rise = sck_q[1] & ~sck_q[2];
   assign sck_fall = ~sck_q[1] & sck_q[2];
   assign cs_rise  = cs_q[1] & ~cs_q[2];
   assign cs_fall  = ~cs_q[1] & cs_q[2];
   assign si       = io_q2[0];
   assign cmd_in   = {rx[6:0], si};
   assign op_done  = (busy_cnt == 12'h001);
   assign write_in_progress      = (busy_cnt != 12'h000) | e_err | p_err;
   assign boot_dly = boot_start_config[bpc_pkg::BOOT_DLY_LSB +: 8];
   assign nib_load = quad_b ? 4'h2 : 4'h8;

   always_comb begin
      status_reg_one = 8'h00;
      status_reg_one[bpc_pkg::SR1_WIP_BIT]   = write_in_progress;
      status_reg_one[bpc_pkg::SR1_WEL_BIT]   = write_enable_latch;
      status_reg_one[bpc_pkg::SR1_E_ERR_BIT] = e_err;
      status_reg_one[bpc_pkg::SR1_P_ERR_BIT] = p_err;
   end

   // command decode at the eighth instruction bit
   always_comb begin
      next_cmd_state = bpc_pkg::DEV_SKIP;
      read_word      = {4{status_reg_one}};
      case (cmd_in)
         bpc_pkg::CMD_BOOT_REG_READ: begin
            next_cmd_state = bpc_pkg::DEV_READ;
            read_word      = swap32(boot_start_config);
         end
         bpc_pkg::CMD_PATTERN_READ: begin
            next_cmd_state = bpc_pkg::DEV_READ;
            read_word      = {4{learning_pattern}};
         end
         bpc_pkg::CMD_STATUS_READ: next_cmd_state = bpc_pkg::DEV_READ;
         bpc_pkg::CMD_BOOT_REG_WRITE,
         bpc_pkg::CMD_PERSIST_PROGRAM,
         bpc_pkg::CMD_VOLATILE_WRITE: begin
            if (write_enable_latch && !write_in_progress) begin
               next_cmd_state = bpc_pkg::DEV_WDATA;
            end
         end
         bpc_pkg::CMD_WRITE_LATCH_SET: begin
            if (!write_in_progress) begin
               next_cmd_state = bpc_pkg::DEV_HOLD;
            end
         end
         bpc_pkg::CMD_CLEAR_FAIL_FLAGS: next_cmd_state = bpc_pkg::DEV_HOLD;
         default: next_cmd_state = bpc_pkg::DEV_SKIP;
      endcase
   end

   // commands execute only on a chip-select rise at the exact bit count
   assign ev_write_latch_set_cmd = cs_rise && state == bpc_pkg::DEV_HOLD && cmd_l == bpc_pkg::CMD_WRITE_LATCH_SET;
   assign ev_clear_fail_flags_cmd = cs_rise && state == bpc_pkg::DEV_HOLD && cmd_l == bpc_pkg::CMD_CLEAR_FAIL_FLAGS;
   assign ev_boot_reg_write_cmd = cs_rise && state == bpc_pkg::DEV_WDATA && cmd_l == bpc_pkg::CMD_BOOT_REG_WRITE
                    && bit_cnt == 6'h20;
   assign ev_pnv  = cs_rise && state == bpc_pkg::DEV_WDATA && cmd_l == bpc_pkg::CMD_PERSIST_PROGRAM
                    && bit_cnt == 6'h08;
   assign ev_wv   = cs_rise && state == bpc_pkg::DEV_WDATA && cmd_l == bpc_pkg::CMD_VOLATILE_WRITE
                    && bit_cnt == 6'h08;

   // fetch of the next boot byte
   assign boot_load = !cs_rise && !reset_evt && (
                      (cs_fall && armed && boot_dly == 8'h00) ||
                      (state == bpc_pkg::DEV_BOOT_WAIT && sck_rise && dly == 8'h01) ||
                      (state == bpc_pkg::DEV_BOOT_DATA && sck_fall && !skip && nib == 4'h1));

   // link sequencer
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state   <= bpc_pkg::DEV_IDLE;
         bit_cnt <= 6'h00;
         rx      <= 32'h0000_0000;
         cmd_l   <= 8'h00;
         tx      <= 32'h0000_0000;
         skip    <= 1'b0;
         nib     <= 4'h0;
         dly     <= 8'h00;
         quad_b  <= 1'b0;
      end else if (cs_rise || reset_evt) begin
         state <= bpc_pkg::DEV_IDLE;
      end else if (boot_load) begin
         state <= bpc_pkg::DEV_BOOT_DATA;
         tx    <= {mem_data, 24'h00_0000};
         nib   <= nib_load;
         skip  <= !cs_fall && state == bpc_pkg::DEV_BOOT_WAIT;
      end else if (cs_fall) begin
         bit_cnt <= 6'h00;
         if (armed) begin
            state <= bpc_pkg::DEV_BOOT_WAIT;
            dly   <= boot_dly;
         end else begin
            state <= bpc_pkg::DEV_CMD;
         end
      end else begin
         case (state)
            bpc_pkg::DEV_IDLE: quad_b <= config_reg_one[bpc_pkg::CR1_QUAD_BIT];
            bpc_pkg::DEV_CMD: begin
               if (sck_rise) begin
                  rx <= {rx[30:0], si};
                  if (bit_cnt == 6'h07) begin
                     cmd_l   <= cmd_in;
                     state   <= next_cmd_state;
                     bit_cnt <= 6'h00;
                     tx      <= read_word;
                     skip    <= 1'b1;
                  end else begin
                     bit_cnt <= bit_cnt + 6'h01;
                  end
               end
            end
            bpc_pkg::DEV_HOLD: begin
               if (sck_rise) begin
                  state <= bpc_pkg::DEV_SKIP;
               end
            end
            bpc_pkg::DEV_WDATA: begin
               if (sck_rise) begin
                  rx <= {rx[30:0], si};
                  if (bit_cnt != 6'h3F) begin
                     bit_cnt <= bit_cnt + 6'h01;
                  end
               end
            end
            bpc_pkg::DEV_READ: begin
               if (sck_fall) begin
                  if (skip) begin
                     skip <= 1'b0;
                  end else begin
                     tx <= {tx[30:0], tx[31]};
                  end
               end
            end
            bpc_pkg::DEV_BOOT_WAIT: begin
               if (sck_rise) begin
                  dly <= dly - 8'h01;
               end
            end
            bpc_pkg::DEV_BOOT_DATA: begin
               if (sck_fall) begin
                  if (skip) begin
                     skip <= 1'b0;
                  end else begin
                     tx  <= quad_b ? {tx[27:0], 4'h0} : {tx[30:0], 1'b0};
                     nib <= nib - 4'h1;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   // boot address and arming
   always_ff @(posedge clk) begin
      if (!nrst) begin
         mem_addr <= 32'h0000_0000;
      end else if (boot_load) begin
         mem_addr <= mem_addr + 32'h0000_0001;
      end else if (state == bpc_pkg::DEV_IDLE && armed) begin
         mem_addr <= {boot_start_config[31:bpc_pkg::BOOT_ADDR_LSB], 9'h000};
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         armed      <= BOOT_INIT[bpc_pkg::BOOT_EN_BIT];
         first_byte <= 1'b0;
      end else begin
         if (reset_evt) begin
            armed <= boot_start_config[bpc_pkg::BOOT_EN_BIT];
         end else if (cs_rise && first_byte) begin
            armed <= 1'b0;
         end
         if (cs_fall) begin
            first_byte <= 1'b0;
         end else if (state == bpc_pkg::DEV_BOOT_DATA && sck_rise && nib == 4'h1) begin
            first_byte <= 1'b1;
         end
      end
   end

   // pin drivers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         spi.dev_io      <= 4'h0;
         spi.dev_io_oe_n <= 4'hF;
      end else if (state == bpc_pkg::DEV_BOOT_DATA && quad_b) begin
         spi.dev_io      <= tx[31:28];
         spi.dev_io_oe_n <= 4'h0;
      end else if (state == bpc_pkg::DEV_BOOT_DATA || state == bpc_pkg::DEV_READ) begin
         spi.dev_io      <= {2'h0, tx[31], 1'b0};
         spi.dev_io_oe_n <= 4'hD;
      end else begin
         spi.dev_io      <= 4'h0;
         spi.dev_io_oe_n <= 4'hF;
      end
   end

   // self-timed operations
   always_ff @(posedge clk) begin
      if (!nrst) begin
         busy_cnt <= 12'h000;
         op_boot_reg_write_cmd  <= 1'b0;
         pend     <= 32'h0000_0000;
      end else if (ev_boot_reg_write_cmd || ev_pnv) begin
         busy_cnt <= bpc_pkg::BUSY_CYC;
         op_boot_reg_write_cmd  <= ev_boot_reg_write_cmd;
         pend     <= rx;
      end else if (busy_cnt != 12'h000) begin
         busy_cnt <= busy_cnt - 12'h001;
      end
   end

   // status flags, set wins over clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         write_enable_latch   <= 1'b0;
         e_err <= 1'b0;
         p_err <= 1'b0;
      end else begin
         if (ev_write_latch_set_cmd) begin
            write_enable_latch <= 1'b1;
         end else if (op_done || ev_wv) begin
            write_enable_latch <= 1'b0;
         end
         if (op_done && op_boot_reg_write_cmd && erase_fail) begin
            e_err <= 1'b1;
         end else if (ev_clear_fail_flags_cmd) begin
            e_err <= 1'b0;
         end
         if (op_done && program_fail) begin
            p_err <= 1'b1;
         end else if (ev_clear_fail_flags_cmd) begin
            p_err <= 1'b0;
         end
      end
   end

   // boot configuration and pattern registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         boot_start_config <= BOOT_INIT;
         pers_pat          <= PATTERN_INIT;
         learning_pattern  <= PATTERN_INIT;
      end else begin
         if (op_done && op_boot_reg_write_cmd && !erase_fail && !program_fail) begin
            boot_start_config <= swap32(pend);
         end
         if (op_done && !op_boot_reg_write_cmd && !program_fail) begin
            pers_pat <= pend[7:0];
         end
         if (ev_wv) begin
            learning_pattern <= rx[7:0];
         end else if (reset_evt) begin
            learning_pattern <= pers_pat;
         end
      end
   end
endmodule

// ### bpc_host.sv
/*
 * Controller end: runs one framed serial transfer per ctrl write made while idle,
 * ordered by software over a classic Wishbone slave.
 * Assumes the device data lines are asynchronous to clk.
 */
`timescale 1ns/100ps
module bpc_host (
   // system
   input  wire logic        clk,
   input  wire logic        nrst,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [3:0]  sel_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // link
   bpc_spi_if.host          spi
);
   bpc_pkg::bpc_host_state_t state;
   bpc_pkg::bpc_host_state_t np;
   logic [31:0] ctrl;
   logic [31:0] txd;
   logic [31:0] rxd;
   logic [31:0] out_sr;
   logic [7:0]  cnt;
   logic [7:0]  np_cnt;
   logic [3:0]  div;
   logic        tick;
   logic [3:0]  io_q1;
   logic [3:0]  io_q2;
   logic        wr;
   logic        go;
   logic [31:0] wmask;
   logic [5:0]  tx_len;
   logic [5:0]  rx_len;
   logic [7:0]  dummy;
   logic [31:0] ctrl_now;

   // a frame without a command picks its first phase at the ctrl write edge
   assign ctrl_now = go ? ((ctrl & ~wmask) | (dat_i & wmask)) : ctrl;
   assign tx_len   = ctrl_now[bpc_pkg::CTRL_TXLEN_LSB +: 6];
   assign rx_len   = ctrl_now[bpc_pkg::CTRL_RXLEN_LSB +: 6];
   assign dummy    = ctrl_now[bpc_pkg::CTRL_DUMMY_LSB +: 8];
   assign wr     = cyc_i && stb_i && we_i && ack_o;
   assign go     = wr && adr_i == bpc_pkg::REG_CTRL && state == bpc_pkg::HST_IDLE;
   assign wmask  = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   assign tick   = (div == bpc_pkg::SCK_HALF_CYC - 4'h1);

   // bus slave: answer one cycle after the request, write at the ack edge
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
         if (cyc_i && stb_i && !ack_o) begin
            if (adr_i == bpc_pkg::REG_CTRL) begin
               dat_o <= ctrl;
            end else if (adr_i == bpc_pkg::REG_TXDATA) begin
               dat_o <= txd;
            end else if (adr_i == bpc_pkg::REG_RXDATA) begin
               dat_o <= rxd;
            end else if (adr_i == bpc_pkg::REG_STATUS) begin
               dat_o <= {31'h0000_0000, state != bpc_pkg::HST_IDLE};
            end else begin
               dat_o <= 32'h0000_0000;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctrl <= 32'h0000_0000;
         txd  <= 32'h0000_0000;
      end else if (wr && state == bpc_pkg::HST_IDLE) begin
         if (adr_i == bpc_pkg::REG_CTRL) begin
            ctrl <= (ctrl & ~wmask) | (dat_i & wmask);
         end else if (adr_i == bpc_pkg::REG_TXDATA) begin
            txd <= (txd & ~wmask) | (dat_i & wmask);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         io_q1 <= 4'hF;
         io_q2 <= 4'hF;
      end else begin
         io_q1 <= spi.io;
         io_q2 <= io_q1;
      end
   end

   // phase that follows the current one, empty phases skipped
   always_comb begin
      np     = bpc_pkg::HST_END;
      np_cnt = 8'h00;
      if (tx_len != 6'h00 && (state == bpc_pkg::HST_IDLE || state == bpc_pkg::HST_CMD)) begin
         np     = bpc_pkg::HST_TX;
         np_cnt = {2'h0, tx_len};
      end else if (dummy != 8'h00 && state != bpc_pkg::HST_DUMMY && state != bpc_pkg::HST_RX) begin
         np     = bpc_pkg::HST_DUMMY;
         np_cnt = dummy;
      end else if (rx_len != 6'h00 && state != bpc_pkg::HST_RX) begin
         np     = bpc_pkg::HST_RX;
         np_cnt = {2'h0, rx_len};
      end
   end

   // half-period divider
   always_ff @(posedge clk) begin
      if (!nrst || state == bpc_pkg::HST_IDLE || tick) begin
         div <= 4'h0;
      end else begin
         div <= div + 4'h1;
      end
   end

   // transfer sequencer
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state            <= bpc_pkg::HST_IDLE;
         spi.sck          <= 1'b0;
         spi.cs_n         <= 1'b1;
         out_sr           <= 32'h0000_0000;
         cnt              <= 8'h00;
         rxd              <= 32'h0000_0000;
      end else if (go) begin
         spi.cs_n <= 1'b0;
         if (dat_i[bpc_pkg::CTRL_NOCMD_BIT]) begin
            state <= np;
            cnt   <= np_cnt;
         end else begin
            state  <= bpc_pkg::HST_CMD;
            out_sr <= {dat_i[bpc_pkg::CTRL_CMD_LSB +: 8], 24'h00_0000};
            cnt    <= 8'h08;
         end
      end else if (tick) begin
         case (state)
            bpc_pkg::HST_IDLE: ;
            bpc_pkg::HST_END: begin
               if (!spi.cs_n) begin
                  spi.cs_n <= 1'b1;
               end else begin
                  state <= bpc_pkg::HST_IDLE;
               end
            end
            default: begin
               if (!spi.sck) begin
                  spi.sck <= 1'b1;
               end else begin
                  spi.sck <= 1'b0;
                  if (state == bpc_pkg::HST_RX) begin
                     rxd <= ctrl[bpc_pkg::CTRL_QUAD_BIT] ? {rxd[27:0], io_q2} : {rxd[30:0], io_q2[1]};
                  end
                  if (cnt == 8'h01) begin
                     state <= np;
                     cnt   <= np_cnt;
                     if (np == bpc_pkg::HST_TX) begin
                        out_sr <= txd;
                     end
                  end else begin
                     cnt    <= cnt - 8'h01;
                     out_sr <= {out_sr[30:0], 1'b0};
                  end
               end
            end
         endcase
      end
   end

   assign spi.host_si      = out_sr[31];
   assign spi.host_si_oe_n = !(state == bpc_pkg::HST_CMD || state == bpc_pkg::HST_TX);
endmodule

// ### bpc_checker.sv
/* link checker: serial wire rules on the joined lines
   assumes clk samples every link signal */
`timescale 1ns/100ps
module bpc_checker (
   // system
   input wire logic       clk,
   input wire logic       nrst,
   // link
   input wire logic       sck,
   input wire logic       cs_n,
   input wire logic       host_si,
   input wire logic       host_si_oe_n,
   input wire logic [3:0] dev_io_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_idle_clk_low: assert property (cs_n |-> !sck) else $error("clock outside frame");
   a_frame_low_first: assert property ($fell(cs_n) |-> !sck [*4]) else $error("frame opens high");
   a_high_half: assert property ($rose(sck) |-> sck [*4] ##1 !sck) else $error("bad high phase");
   a_low_half: assert property ($fell(sck) |-> !sck [*4]) else $error("short low phase");
   a_si_steady: assert property (sck |-> $stable(host_si)) else $error("data moved");
   a_no_clash: assert property (!dev_io_oe_n[0] |-> host_si_oe_n) else $error("line clash");
   a_dev_release: assert property ($rose(cs_n) |-> ##6 (&dev_io_oe_n)) else $error("device still drives");
   a_cs_gap: assert property ($rose(cs_n) |-> cs_n [*4]) else $error("short gap");
endmodule

// ### bpc_test.sv
/* bench: controller and device joined, driven over the bus
   assumes one clk for both ends */
`timescale 1ns/100ps
module bpc_test;
   localparam logic [31:0] SR_RD = 32'h0002_0005;
   logic        clk, nrst, req, we, ack, rst_evt, pfail, efail;
   logic [7:0]  adr, st, pattern, cr1;
   logic [31:0] wd, rdat, rx, maddr, cfg;
   int          num_errors = 0, checks_done = 0;
   bpc_spi_if   spi_bus();
   bpc_host u_bpc_host (.clk(clk), .nrst(nrst), .cyc_i(req), .stb_i(req), .we_i(we), .adr_i(adr), .dat_i(wd),
      .sel_i(4'hF), .dat_o(rdat), .ack_o(ack), .spi(spi_bus.host));
   bpc_device #(.BOOT_INIT(32'h0000_0205)) u_bpc_device (.clk(clk), .nrst(nrst), .reset_evt(rst_evt),
      .config_reg_one(cr1), .mem_addr(maddr), .mem_data(maddr[9:2]), .erase_fail(efail), .program_fail(pfail),
      .status_reg_one(st), .boot_start_config(cfg), .learning_pattern(pattern), .spi(spi_bus.device));
   bpc_checker u_bpc_checker (.clk(clk), .nrst(nrst), .sck(spi_bus.sck), .cs_n(spi_bus.cs_n),
      .host_si(spi_bus.host_si), .host_si_oe_n(spi_bus.host_si_oe_n), .dev_io_oe_n(spi_bus.dev_io_oe_n));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rx = rdat;
      req <= 1'b0;
   endtask
   task automatic xfer(input logic [31:0] ctrl, input logic [31:0] tx);
      wb(1'b1, bpc_pkg::REG_TXDATA, tx);
      wb(1'b1, bpc_pkg::REG_CTRL, ctrl);
      do wb(1'b0, bpc_pkg::REG_STATUS, 32'h0); while (rx[0] !== 1'b0);
      wb(1'b0, bpc_pkg::REG_RXDATA, 32'h0);
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic test_boot();
      for (int i = 0; i < 3; i++) begin
         xfer((i == 2) ? 32'h3022_0000 : 32'h1022_0000, 32'h0);
         check(rx & 32'hFF, (i == 1) ? 32'hFF : 32'h80);
         if (i == 2) check(rx, 32'h8080_8080);
         rst_evt <= (i == 1);
         if (i == 1) cr1 <= 8'h02;
         @(posedge clk);
         rst_evt <= 1'b0;
      end
      $display("boot done");
   endtask
   task automatic test_boot_reg();
      xfer(32'h000A_0014, 32'h0);
      check(rx, 32'h0200_0005);
      xfer(32'h0000_2015, 32'h0056_3412);
      repeat (450) @(posedge clk);
      check(cfg, 32'h0000_0205);
      xfer(32'h0000_0006, 32'h0);
      xfer(SR_RD, 32'h0);
      check(rx & 32'hFF, 32'h02);
      xfer(32'h0000_2015, 32'h0056_3412);
      repeat (450) @(posedge clk);
      check(cfg, 32'h1234_5600);
      xfer(SR_RD, 32'h0);
      check(rx & 32'hFF, 32'h00);
      $display("boot register done");
   endtask
   task automatic test_pattern();
      xfer(32'h0000_0006, 32'h0);
      xfer(32'h0000_084A, 32'h5C00_0000);
      check({24'h0, pattern}, 32'h5C);
      xfer(32'h0004_0041, 32'h0);
      check(rx & 32'hFFFF, 32'h5C5C);
      $display("pattern done");
   endtask
   task automatic test_fail_flags();
      pfail <= 1'b1;
      xfer(32'h0000_0006, 32'h0);
      xfer(32'h0000_0843, 32'hA700_0000);
      repeat (450) @(posedge clk);
      pfail <= 1'b0;
      xfer(SR_RD, 32'h0);
      check(rx & 32'h63, 32'h41);
      check({24'h0, st}, 32'h41);
      xfer(32'h0000_0030, 32'h0);
      xfer(SR_RD, 32'h0);
      check(rx & 32'h63, 32'h00);
      efail <= 1'b1;
      xfer(32'h0000_0006, 32'h0);
      xfer(32'h0000_2015, 32'h0056_3412);
      repeat (450) @(posedge clk);
      efail <= 1'b0;
      xfer(SR_RD, 32'h0);
      check(rx & 32'h63, 32'h21);
      check(cfg, 32'h1234_5600);
      xfer(32'h0000_0030, 32'h0);
      xfer(32'h0000_0006, 32'h0);
      xfer(32'h0000_0030, 32'h0);
      xfer(SR_RD, 32'h0);
      check(rx & 32'h63, 32'h02);
      $display("fail flags done");
   endtask
   initial begin
      {nrst, req, we, rst_evt, pfail, efail, cr1, adr, wd} = '0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      test_boot();
      test_boot_reg();
      test_pattern();
      test_fail_flags();
      report_and_stop();
   end
   initial begin
      repeat (30000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end
endmodule
